//--- rtl/swseq_top.sv
// Functional notes
// R1 - a 1 shifted into the serial word's top bit puts the device to sleep on the rising chip-select edge.
// R2 - chip select and reset input low together put the device to sleep at once.
// R3 - while asleep the pump and bias are off and every gate output is held off.
// R4 - entering sleep clears the serial control and fault bits and all deglitch timers.
// R5 - the first falling chip-select edge after sleep entry ends sleep.
// R6 - a rising edge on one channel input ends sleep only while the other three are low.
// R7 - after sleep ends, gates stay off for about 512 us while pump and analog settle.
// R8 - gate enables default low and go high only when the logic actively drives them.
// R9 - turn-on requests made during the settling delay take effect only after it ends.
`timescale 1ns/1ps
`default_nettype none
module swseq_top
  import swseq_pkg::*;
#(
  parameter int ACTIVE_CYC = ACTIVE_DELAY_CYC,
  parameter int NCH        = NUM_CHAN,
  parameter int SW         = SER_WIDTH
) (
  input  wire logic           CORE_CLK,
  input  wire logic           RESET_N,
  input  wire logic           CHIP_SEL_N,
  input  wire logic           SCLK,
  input  wire logic           SERIAL_IN,
  input  wire logic           RESET_IN_N,
  input  wire logic [NCH-1:0] CHAN_IN,
  input  wire logic           FAULT_EVENT,
  output logic      [NCH-1:0] GATE_OUT,
  output logic                PUMP_EN,
  output logic                BIAS_EN,
  output logic                ASLEEP,
  output logic                SETTLING,
  output logic      [SW-1:0]  SER_CTRL,
  output logic                FAULT_FLAG,
  output logic      [15:0]    DEGLITCH_CNT
);
  localparam int CW = $clog2(ACTIVE_CYC + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(ACTIVE_CYC - 1);

  logic cs_level, cs_rise, cs_fall;
  logic sck_level, sck_rise;
  logic [NCH-1:0] ch_level, ch_rise;

  swseq_edge u_cs (.clk(CORE_CLK), .rst_n(RESET_N), .din(CHIP_SEL_N),
                   .level(cs_level), .rise(cs_rise), .fall(cs_fall));
  swseq_edge u_sck (.clk(CORE_CLK), .rst_n(RESET_N), .din(SCLK),
                    .level(sck_level), .rise(sck_rise), .fall());

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      swseq_edge u_ch (.clk(CORE_CLK), .rst_n(RESET_N), .din(CHAN_IN[g]),
                       .level(ch_level[g]), .rise(ch_rise[g]), .fall());
    end
  endgenerate

  swseq_state_t   state, next_state;
  logic [SW-1:0]  shift, next_shift;
  logic [SW-1:0]  ctrl, next_ctrl;
  logic           fault, next_fault;
  logic [15:0]    dgl, next_dgl;
  logic [CW-1:0]  cnt, next_cnt;
  logic [NCH-1:0] gate, next_gate;
  logic           pump, next_pump;
  logic           sleep_req, wake_req, chan_wake;

  // one-hot check: the rising channel alone may be high
  always_comb begin
    chan_wake = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (ch_rise[i] && ((CHAN_IN & ~(NCH'(1) << i)) == '0)) begin
        chan_wake = 1'b1; // R6
      end
    end
  end

  // serial latch on rising select uses the shift word's top bit
  assign sleep_req = (cs_rise && shift[SW-1]) // R1
                   || (!CHIP_SEL_N && !RESET_IN_N); // R2
  assign wake_req = cs_fall || chan_wake; // R5 R6

  // sequencer; sleep entry takes priority over any wake in the same cycle
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      SWSEQ_RUN: begin
        if (sleep_req) begin
          next_state = SWSEQ_SLEEP;
        end
      end
      SWSEQ_SLEEP: begin
        if (wake_req && !(!CHIP_SEL_N && !RESET_IN_N)) begin
          next_state = SWSEQ_SETTLE; // R5
          next_cnt   = '0;
        end
      end
      SWSEQ_SETTLE: begin
        if (sleep_req) begin
          next_state = SWSEQ_SLEEP;
        end else if (cnt == SETTLE_LAST) begin
          next_state = SWSEQ_RUN; // R7
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
      default: begin
        next_state = SWSEQ_SLEEP;
      end
    endcase
    // pump and bias share one flop so both outputs come straight from a register
    next_pump = (next_state != SWSEQ_SLEEP); // R3
  end

  // serial word, fault bit and deglitch timer; all cleared in sleep
  always_comb begin
    next_shift = shift;
    next_ctrl  = ctrl;
    next_fault = fault;
    next_dgl   = dgl;
    if (next_state == SWSEQ_SLEEP) begin
      next_shift = '0; // R4
      next_ctrl  = '0; // R4
      next_fault = 1'b0; // R4
      next_dgl   = '0; // R4
    end else begin
      if (!CHIP_SEL_N && sck_rise) begin
        next_shift = {shift[SW-2:0], SERIAL_IN};
      end
      if (cs_rise) begin
        next_ctrl = shift;
      end
      // sticky fault, sleep clear wins over set; stands in for the real fault logic
      if (FAULT_EVENT) begin
        next_fault = 1'b1;
      end
      // timer only advances while some channel is driven
      if (|gate && dgl != 16'hffff) begin
        next_dgl = dgl + 16'h0001;
      end else if (!(|gate)) begin
        next_dgl = '0;
      end
    end
  end

  // gates follow requests only in run; held requests apply on delay end
  always_comb begin
    next_gate = '0; // R8
    if (next_state == SWSEQ_RUN) begin
      // live pin level, so a request raised in the last settle cycle is not lost
      next_gate = CHAN_IN | ctrl[NCH-1:0]; // R9
    end
  end

  // registers only
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= SWSEQ_SLEEP;
      shift <= '0;
      ctrl  <= '0;
      fault <= 1'b0;
      dgl   <= '0;
      cnt   <= '0;
      gate  <= '0;
      pump  <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      ctrl  <= next_ctrl;
      fault <= next_fault;
      dgl   <= next_dgl;
      cnt   <= next_cnt;
      gate  <= next_gate;
      pump  <= next_pump;
    end
  end

  // outputs straight from flip-flops
  assign GATE_OUT     = gate; // R3
  assign PUMP_EN      = pump; // R3
  assign BIAS_EN      = pump; // R3
  assign ASLEEP       = state[0];
  assign SETTLING     = state[1];
  assign SER_CTRL     = ctrl;
  assign FAULT_FLAG   = fault;
  assign DEGLITCH_CNT = dgl;

  // unused registered levels kept only for edge pulses
  logic unused_levels;
  assign unused_levels = cs_level ^ sck_level ^ (^ch_level);

  sequence s_wake;
    (state == SWSEQ_SLEEP) && wake_req && !sleep_req;
  endsequence

  property p_serial_sleep;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (cs_rise && shift[SW-1]) |=> (state == SWSEQ_SLEEP);
  endproperty
  a_serial_sleep: assert property (p_serial_sleep) else $error("serial sleep missed"); // R1

  property p_par_sleep;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (!CHIP_SEL_N && !RESET_IN_N) |=> ASLEEP;
  endproperty
  a_par_sleep: assert property (p_par_sleep) else $error("parallel sleep missed"); // R2

  property p_sleep_off;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      ASLEEP |-> (GATE_OUT == '0 && !PUMP_EN && !BIAS_EN);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("outputs active in sleep"); // R3

  property p_clear;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      ASLEEP |-> (SER_CTRL == '0 && !FAULT_FLAG && DEGLITCH_CNT == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("state not cleared in sleep"); // R4

  property p_cs_wake;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (ASLEEP && cs_fall && RESET_IN_N) |=> SETTLING;
  endproperty
  a_cs_wake: assert property (p_cs_wake) else $error("select fall did not wake"); // R5

  property p_chan_wake;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (ASLEEP && $rose(CHAN_IN[0]) && CHAN_IN[NCH-1:1] == '0 && CHIP_SEL_N) |=> SETTLING;
  endproperty
  a_chan_wake: assert property (p_chan_wake) else $error("channel edge did not wake"); // R6

  property p_settle_gates_off;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      s_wake ##1 (SETTLING && !sleep_req) [*8] |-> (GATE_OUT == '0);
  endproperty
  a_settle_gates_off: assert property (p_settle_gates_off) else $error("gate on during settle"); // R7

  property p_gate_needs_run;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (GATE_OUT != '0) |-> (state == SWSEQ_RUN) && !ASLEEP;
  endproperty
  a_gate_needs_run: assert property (p_gate_needs_run) else $error("gate driven outside run"); // R8

  property p_held_request;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (SETTLING && cnt == SETTLE_LAST && !sleep_req && CHAN_IN[0]) |=> GATE_OUT[0];
  endproperty
  a_held_request: assert property (p_held_request) else $error("held request lost"); // R9
endmodule
`default_nettype wire

//--- rtl/swseq_pkg.sv
package swseq_pkg;
  localparam int NUM_CHAN = 4;
  localparam int SER_WIDTH = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACTIVE_DELAY_US = 512;
  // longest time rounds down; with these figures it is exact
  localparam int ACTIVE_DELAY_CYC = (ACTIVE_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam logic [1:0] SLEEP_RST = 2'h1;
  typedef enum logic [1:0] {
    SWSEQ_RUN    = 2'b00,
    SWSEQ_SLEEP  = 2'b01,
    SWSEQ_SETTLE = 2'b10
  } swseq_state_t;
endpackage

//--- rtl/swseq_edge.sv
`timescale 1ns/1ps
`default_nettype none
// registered copy of a synchronous input with rise and fall pulses
module swseq_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic prev;
  logic next_prev;

  // next value is simply the sampled input
  always_comb begin
    next_prev = din;
  end

  // idle-high reset suits the active-low select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end

  assign level = prev;
  assign rise  = din & ~prev;
  assign fall  = ~din & prev;
endmodule
`default_nettype wire

//--- bench/swseq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: serial frames and parallel channel levels, all moved on the falling edge
module swseq_host_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            sclk,
  output logic            sdata,
  output logic            rst_in_n,
  output logic [3:0]      chan
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
    rst_in_n = 1'b1;
    chan = 4'h0;
  end
  // one select frame, msb first; the data line flips once released, nothing holds it
  task automatic frame(input logic [7:0] word);
    @(negedge clk) cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk) sdata = word[i];
      sclk = 1'b0;
      @(negedge clk) sclk = 1'b1;
    end
    @(negedge clk) sclk = 1'b0;
    @(negedge clk) cs_n = 1'b1;
    sdata = ~sdata;
  endtask
  // select and reset pin low in the same cycle
  task automatic pair_sleep();
    @(negedge clk) cs_n = 1'b0;
    rst_in_n = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    @(negedge clk) rst_in_n = 1'b1;
  endtask
  task automatic set_chan(input logic [3:0] v);
    @(negedge clk) chan = v;
  endtask
endmodule
`default_nettype wire

//--- bench/sleep_wake_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_sequencer_tb_top;
  localparam int ACT = 20;
  logic        clk, reset_n, cs_n, sclk, sdata, rst_in_n, fault;
  logic        pump, bias, asleep, settling, fault_flag;
  logic [3:0]  chan, gate;
  logic [7:0]  ser_ctrl;
  logic [15:0] dcnt;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  swseq_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdata(sdata),
                         .rst_in_n(rst_in_n), .chan(chan));
  swseq_top #(.ACTIVE_CYC(ACT)) DUT (.CORE_CLK(clk), .RESET_N(reset_n), .CHIP_SEL_N(cs_n),
    .SCLK(sclk), .SERIAL_IN(sdata), .RESET_IN_N(rst_in_n), .CHAN_IN(chan), .FAULT_EVENT(fault),
    .GATE_OUT(gate), .PUMP_EN(pump), .BIAS_EN(bias), .ASLEEP(asleep), .SETTLING(settling),
    .SER_CTRL(ser_ctrl), .FAULT_FLAG(fault_flag), .DEGLITCH_CNT(dcnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a hang would stall the scenarios; far above their total length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  // gates held off for the whole delay, then the pending request shows
  task automatic settle_run(input logic [3:0] want);
    int n;
    n = 0;
    repeat (4) if (settling !== 1'b1) @(negedge clk);
    while (settling === 1'b1 && n < ACT + 4) begin
      check("gate_settle", gate, 0);
      n++;
      @(negedge clk);
    end
    check("settle_len", n, ACT);
    repeat (2) @(negedge clk);
    check("gate_after", gate, want);
  endtask

  task automatic s_select_wake();
    check("asleep0", asleep, 1);
    check("pump0", {pump, bias, gate}, 0);
    fork
      host.frame(8'h05);
      settle_run(4'h5);
    join
    check("pump1", {pump, bias, asleep}, 3'h6);
    check("ser_ctrl", ser_ctrl, 8'h05);
  endtask

  task automatic s_serial_sleep();
    @(negedge clk) fault = 1'b1;
    @(negedge clk) fault = 1'b0;
    host.set_chan(4'h4);
    repeat (3) @(negedge clk);
    check("fault_set", fault_flag, 1);
    check("dgl_run", dcnt, 8);
    host.frame(8'h85);
    repeat (3) @(negedge clk);
    check("asleep_ser", asleep, 1);
    check("off_ser", {pump, bias, gate}, 0);
    check("cleared", {ser_ctrl, fault_flag, dcnt}, 0);
  endtask

  task automatic s_chan_wake();
    host.set_chan(4'hc);
    repeat (5) @(negedge clk);
    check("refused", {asleep, settling}, 2'h2);
    host.set_chan(4'h0);
    repeat (2) @(negedge clk);
    host.set_chan(4'h1);
    settle_run(4'h1);
  endtask

  task automatic s_pair_sleep();
    host.pair_sleep();
    repeat (2) @(negedge clk);
    check("asleep_pair", asleep, 1);
    check("off_pair", {pump, bias, gate}, 0);
  endtask

  initial begin
    reset_n = 1'b0;
    fault = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    s_select_wake();
    s_serial_sleep();
    s_chan_wake();
    s_pair_sleep();
    complete_run();
  end
endmodule
`default_nettype wire
